// ### logic/priority_vector_interrupt_ctrl.sv
// Vectored three-level interrupt controller facing the processor core
`timescale 1ns/100ps
`default_nettype none
module priority_vector_interrupt_ctrl
  import pvic_pkg::*;
(
  input wire logic I_CLOCK,
  input wire logic I_RST,
  input wire logic I_EXT_PIN_IRQ_A,
  input wire logic I_EXT_PIN_IRQ_B,
  input wire logic I_EXT_PIN_IRQ_C,
  input wire logic I_EXT_PIN_IRQ_D,
  input wire logic I_TIMER0_LOW_BYTE_IRQ,
  input wire logic I_TIMER0_HIGH_BYTE_IRQ,
  input wire logic I_TIMER1_LOW_BYTE_IRQ,
  input wire logic I_TIMER1_HIGH_BYTE_IRQ,
  input wire logic I_BASE_TIMER_IRQ,
  input wire logic I_CALENDAR_IRQ,
  input wire logic I_SYNC_SERIAL_A_IRQ,
  input wire logic I_ASYNC_PORT_IRQ,
  input wire logic I_SYNC_SERIAL_B_IRQ,
  input wire logic I_ASYNC_SEND_IRQ,
  input wire logic I_ANALOG_CONV_IRQ,
  input wire logic I_TIMER_SIX_IRQ,
  input wire logic I_TIMER_SEVEN_IRQ,
  input wire logic I_SPI_IRQ,
  input wire logic I_PORT0_CHANGE_IRQ,
  input wire logic I_TIMER_FOUR_IRQ,
  input wire logic I_TIMER_FIVE_IRQ,
  input wire logic [NUM_VECTORS-1:0] I_LEVEL_SEL,
  input wire logic I_IRQ_ACK,
  input wire logic I_IRQ_RETURN,
  output logic O_IRQ_REQ,
  output logic [ADDR_W-1:0] O_IRQ_VECTOR,
  output logic [1:0] O_IRQ_LEVEL,
  output logic [2:0] O_IN_SERVICE,
  output logic [1:0] O_SERVICE_LEVEL
);

  typedef enum logic {
    ST_IDLE,
    ST_OFFER
  } state_t;

  function automatic logic [ADDR_W-1:0] vector_addr(
    input logic [VIDX_W-1:0] idx
  );
    vector_addr = VEC_BASE + ADDR_W'(idx) * VEC_STEP;
  endfunction

  // Highest level whose in-service bit is set
  function automatic level_t top_of(input logic [2:0] mask);
    if (mask[2]) begin
      top_of = LVL_TOP;
    end else if (mask[1]) begin
      top_of = LVL_HIGH;
    end else if (mask[0]) begin
      top_of = LVL_LOW;
    end else begin
      top_of = LVL_NONE;
    end
  endfunction

  // Pin synchroniser; only the second stage is looked at
  logic [NUM_PINS-1:0] pins_raw;
  logic [NUM_PINS-1:0] sync1_q;
  logic [NUM_PINS-1:0] sync1_d;
  logic [NUM_PINS-1:0] sync2_q;
  logic [NUM_PINS-1:0] sync2_d;

  assign pins_raw = {I_EXT_PIN_IRQ_D, I_EXT_PIN_IRQ_C,
                     I_EXT_PIN_IRQ_B, I_EXT_PIN_IRQ_A};

  always_comb begin
    sync1_d = pins_raw;
    sync2_d = sync1_q;
  end

  generate
    for (genvar g = 0; g < NUM_PINS; g++) begin : g_sync
      always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
          sync1_q[g] <= SYNC_RESET[g];
          sync2_q[g] <= SYNC_RESET[g];
        end else begin
          sync1_q[g] <= sync1_d[g];
          sync2_q[g] <= sync2_d[g];
        end
      end
    end
  endgenerate

  // Source flags stay in the peripherals, so no latch here
  logic [NUM_VECTORS-1:0] pending;

  always_comb begin
    pending = '0;
    pending[VIDX_PIN_A] = sync2_q[0];
    pending[VIDX_PIN_B] = sync2_q[1];
    pending[VIDX_PIN_C_TIMER0] = sync2_q[2] | I_TIMER0_LOW_BYTE_IRQ;
    pending[VIDX_PIN_D_CLOCKS] = sync2_q[3] | I_BASE_TIMER_IRQ |
                                 I_CALENDAR_IRQ;
    pending[VIDX_TIMER0_HIGH] = I_TIMER0_HIGH_BYTE_IRQ;
    pending[VIDX_T1] = I_TIMER1_LOW_BYTE_IRQ | I_TIMER1_HIGH_BYTE_IRQ;
    pending[VIDX_SERIAL_A] = I_SYNC_SERIAL_A_IRQ | I_ASYNC_PORT_IRQ;
    pending[VIDX_SERIAL_B] = I_SYNC_SERIAL_B_IRQ | I_ASYNC_SEND_IRQ;
    pending[VIDX_CONV_GROUP] = I_ANALOG_CONV_IRQ | I_TIMER_SIX_IRQ |
                               I_TIMER_SEVEN_IRQ | I_SPI_IRQ;
    pending[VIDX_PORT_GROUP] = I_PORT0_CHANGE_IRQ | I_TIMER_FOUR_IRQ |
                               I_TIMER_FIVE_IRQ;
  end

  // In-service mask, one bit per level: bit 0 low, 1 high, 2 top
  logic [2:0] in_service_q;
  logic [2:0] in_service_d;
  level_t service_level;
  level_t service_after_ret;
  logic [2:0] after_ret;
  level_t svc_q;
  level_t svc_d;

  assign service_level = top_of(in_service_q);

  logic arb_valid;
  logic [VIDX_W-1:0] arb_index;
  level_t arb_level;

  // A return in this cycle lowers the bar before the arbiter judges
  pvic_arbiter u_arbiter (
    .i_pending(pending),
    .i_level_sel(I_LEVEL_SEL),
    .i_service_level(service_after_ret),
    .o_valid(arb_valid),
    .o_index(arb_index),
    .o_level(arb_level)
  );

  state_t state_q;
  state_t state_d;
  logic req_q;
  logic req_d;
  logic [ADDR_W-1:0] vec_q;
  logic [ADDR_W-1:0] vec_d;
  level_t lvl_q;
  level_t lvl_d;
  logic take;

  assign take = I_IRQ_ACK && req_q;

  always_comb begin
    after_ret = in_service_q;
    if (I_IRQ_RETURN) begin
      case (service_level)
        LVL_TOP: after_ret[2] = 1'b0;
        LVL_HIGH: after_ret[1] = 1'b0;
        LVL_LOW: after_ret[0] = 1'b0;
        default: after_ret = in_service_q;
      endcase
    end
    service_after_ret = top_of(after_ret);
    in_service_d = after_ret;
    // Ack pushes the level that was on offer, not a fresh one
    if (take) begin
      case (lvl_q)
        LVL_TOP: in_service_d[2] = 1'b1;
        LVL_HIGH: in_service_d[1] = 1'b1;
        LVL_LOW: in_service_d[0] = 1'b1;
        default: in_service_d = after_ret;
      endcase
    end
    // Registered copy so the port comes straight from a flop
    svc_d = top_of(in_service_d);
  end

  // The offer tracks the arbiter each cycle until taken, one cycle behind, so a
  // withdrawn or outranked request stays on offer one more cycle and can be taken then
  always_comb begin
    state_d = state_q;
    req_d = req_q;
    vec_d = vec_q;
    lvl_d = lvl_q;
    case (state_q)
      ST_IDLE: begin
        if (arb_valid) begin
          state_d = ST_OFFER;
          req_d = 1'b1;
          vec_d = vector_addr(arb_index);
          lvl_d = arb_level;
        end
      end
      ST_OFFER: begin
        if (take) begin
          // One idle cycle so the next judgement sees the new level
          state_d = ST_IDLE;
          req_d = 1'b0;
          lvl_d = LVL_NONE;
        end else if (arb_valid) begin
          vec_d = vector_addr(arb_index);
          lvl_d = arb_level;
        end else begin
          state_d = ST_IDLE;
          req_d = 1'b0;
          lvl_d = LVL_NONE;
        end
      end
      default: begin
        state_d = ST_IDLE;
        req_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      state_q <= ST_IDLE;
      req_q <= 1'b0;
      vec_q <= '0;
      lvl_q <= LVL_NONE;
      in_service_q <= IN_SERVICE_RESET;
      svc_q <= LVL_NONE;
    end else begin
      state_q <= state_d;
      req_q <= req_d;
      vec_q <= vec_d;
      lvl_q <= lvl_d;
      in_service_q <= in_service_d;
      svc_q <= svc_d;
    end
  end

  assign O_IRQ_REQ = req_q;
  assign O_IRQ_VECTOR = vec_q;
  assign O_IRQ_LEVEL = lvl_q;
  assign O_IN_SERVICE = in_service_q;
  assign O_SERVICE_LEVEL = svc_q;

endmodule
`default_nettype wire

// ### logic/pvic_arbiter.sv
// Level and address arbiter for the vectored interrupt controller
`timescale 1ns/100ps
`default_nettype none
module pvic_arbiter
  import pvic_pkg::*;
(
  input wire logic [NUM_VECTORS-1:0] i_pending,
  input wire logic [NUM_VECTORS-1:0] i_level_sel,
  input wire level_t i_service_level,
  output logic o_valid,
  output logic [VIDX_W-1:0] o_index,
  output level_t o_level
);

  // Vectors 1 and 2 choose top or low, the rest high or low
  function automatic level_t vector_level(input int idx, input logic sel);
    if (!sel) begin
      vector_level = LVL_LOW;
    end else if (idx < NUM_TOP_CAPABLE) begin
      vector_level = LVL_TOP;
    end else begin
      vector_level = LVL_HIGH;
    end
  endfunction

  always_comb begin
    level_t lvl;
    lvl = LVL_NONE;
    o_valid = 1'b0;
    o_index = '0;
    o_level = LVL_NONE;
    // Walk downward so an equal level at a lower address overrides
    for (int i = NUM_VECTORS - 1; i >= 0; i--) begin
      lvl = vector_level(i, i_level_sel[i]);
      if (i_pending[i] && lvl > i_service_level &&
          lvl >= o_level) begin
        o_valid = 1'b1;
        o_index = VIDX_W'(i);
        o_level = lvl;
      end
    end
  end

endmodule
`default_nettype wire

// ### logic/pvic_pkg.sv
// Constants and types shared by the vectored interrupt controller
// What this block does
// - Three levels ordered top over high over low, used in every decision.
// - While in service, refuse requests at or below that level; nest higher.
// - Simultaneous requests on different vectors: highest assigned level wins.
// - Same level ties go to the numerically lowest vector address.
// - Twenty-one sources merge onto ten vectors; one address per grant.
// - Addresses 00003H step eight to 0004BH; vectors 1,2 pins, top or low.
// - Vectors 3 to 10 high or low; converter, timers, SPI share 00043H.
// - Pin d, base timer and calendar clock share vector address 0001BH.
// - Port 0 change, timer four and five share 0004BH, high or low.
`default_nettype none
package pvic_pkg;

  localparam int NUM_VECTORS = 10;
  localparam int NUM_SOURCES = 21;
  localparam int NUM_PINS = 4;
  localparam int VIDX_W = 4;
  localparam int ADDR_W = 20;
  localparam int NUM_TOP_CAPABLE = 2;

  localparam logic [ADDR_W-1:0] VEC_BASE = 20'h00003;
  localparam logic [ADDR_W-1:0] VEC_STEP = 20'h00008;

  // Vector index of each source group, counted from zero
  localparam logic [VIDX_W-1:0] VIDX_PIN_A = 4'h0;
  localparam logic [VIDX_W-1:0] VIDX_PIN_B = 4'h1;
  localparam logic [VIDX_W-1:0] VIDX_PIN_C_TIMER0 = 4'h2;
  localparam logic [VIDX_W-1:0] VIDX_PIN_D_CLOCKS = 4'h3;
  localparam logic [VIDX_W-1:0] VIDX_TIMER0_HIGH = 4'h4;
  localparam logic [VIDX_W-1:0] VIDX_T1 = 4'h5;
  localparam logic [VIDX_W-1:0] VIDX_SERIAL_A = 4'h6;
  localparam logic [VIDX_W-1:0] VIDX_SERIAL_B = 4'h7;
  localparam logic [VIDX_W-1:0] VIDX_CONV_GROUP = 4'h8;
  localparam logic [VIDX_W-1:0] VIDX_PORT_GROUP = 4'h9;

  // Numeric order of the codes is the priority order
  typedef enum logic [1:0] {
    LVL_NONE = 2'h0,
    LVL_LOW = 2'h1,
    LVL_HIGH = 2'h2,
    LVL_TOP = 2'h3
  } level_t;

  localparam logic [2:0] IN_SERVICE_RESET = 3'h0;
  localparam logic [NUM_PINS-1:0] SYNC_RESET = 4'h0;

endpackage
`default_nettype wire

// ### tb/priority_vector_interrupt_ctrl_tb_top.sv
// Randomised self-checking bench for the vectored interrupt controller
`timescale 1ns/100ps
`default_nettype none
module priority_vector_interrupt_ctrl_tb_top;
  logic clk, rst, ret, en, ack, req;
  logic [20:0] src;
  logic [9:0] sel;
  logic [1:0] dly, lvl, slv;
  logic [19:0] vec;
  logic [2:0] ins, ms;
  int err_total, tests_run;
  int vm[21] = '{0,1,2,2,3,3,3,4,5,5,6,6,7,7,8,8,8,8,9,9,9};
  priority_vector_interrupt_ctrl dut (.I_CLOCK(clk), .I_RST(rst),
    .I_EXT_PIN_IRQ_A(src[0]), .I_EXT_PIN_IRQ_B(src[1]),
    .I_EXT_PIN_IRQ_C(src[2]), .I_TIMER0_LOW_BYTE_IRQ(src[3]),
    .I_EXT_PIN_IRQ_D(src[4]), .I_BASE_TIMER_IRQ(src[5]),
    .I_CALENDAR_IRQ(src[6]), .I_TIMER0_HIGH_BYTE_IRQ(src[7]),
    .I_TIMER1_LOW_BYTE_IRQ(src[8]), .I_TIMER1_HIGH_BYTE_IRQ(src[9]),
    .I_SYNC_SERIAL_A_IRQ(src[10]), .I_ASYNC_PORT_IRQ(src[11]),
    .I_SYNC_SERIAL_B_IRQ(src[12]), .I_ASYNC_SEND_IRQ(src[13]),
    .I_ANALOG_CONV_IRQ(src[14]), .I_TIMER_SIX_IRQ(src[15]),
    .I_TIMER_SEVEN_IRQ(src[16]), .I_SPI_IRQ(src[17]),
    .I_PORT0_CHANGE_IRQ(src[18]), .I_TIMER_FOUR_IRQ(src[19]),
    .I_TIMER_FIVE_IRQ(src[20]), .I_LEVEL_SEL(sel), .I_IRQ_ACK(ack),
    .I_IRQ_RETURN(ret), .O_IRQ_REQ(req), .O_IRQ_VECTOR(vec),
    .O_IRQ_LEVEL(lvl), .O_IN_SERVICE(ins), .O_SERVICE_LEVEL(slv));
  pvic_core_model core (.i_clock(clk), .i_rst(rst), .i_req(req),
    .i_enable(en), .i_delay(dly), .o_ack(ack));
  task automatic wrap_up;
    if (err_total == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check;
    logic er;
    logic [1:0] el, lv;
    logic [19:0] ev;
    logic [9:0] p;
    int bar;
    p = '0;
    er = 1'b0;
    el = 2'h0;
    ev = 20'h00000;
    for (int k = 0; k < 21; k++) if (src[k]) p[vm[k]] = 1'b1;
    bar = ms[2] ? 3 : ms[1] ? 2 : int'(ms[0]);
    for (int i = 9; i >= 0; i--) begin
      lv = !sel[i] ? 2'h1 : i < 2 ? 2'h3 : 2'h2;
      // Downward scan so equal levels fall to the lower address
      if (p[i] && lv > bar && lv >= el) begin
        er = 1'b1;
        el = lv;
        ev = 20'h00003 + 20'(8 * i);
      end
    end
    tests_run++;
    if (req !== er || lvl !== el || ins !== ms || slv !== 2'(bar) ||
        (er && vec !== ev)) begin
      err_total++;
      $display("ERROR %0t offer %h %h %h mask %b", $time, req, vec, lvl, ins);
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    int n;
    rst = 1'b1;
    {src, sel, ret, en, dly, ms} = '0;
    n = $urandom(32'hB7D7);
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int t = 0; t < 400; t++) begin
      @(posedge clk);
      src <= 21'($urandom & $urandom & $urandom);
      sel <= 10'($urandom);
      dly <= 2'($urandom % 3);
      repeat (4) @(posedge clk);
      @(negedge clk);
      check;
      n = $urandom % 3;
      @(posedge clk);
      if (n == 0 && ms != 3'h0) begin
        ret <= 1'b1;
        @(posedge clk);
        ret <= 1'b0;
        ms[ms[2] ? 2 : ms[1] ? 1 : 0] = 1'b0;
      end else if (n == 1 && req) begin
        en <= 1'b1;
        for (int w = 0; w < 8 && !ack; w++) @(posedge clk);
        if (!ack) begin
          err_total++;
          $display("ERROR %0t no accept from core", $time);
          wrap_up;
        end
        ms[lvl - 2'h1] = 1'b1;
        en <= 1'b0;
      end
    end
    wrap_up;
  end
endmodule
`default_nettype wire

// ### tb/pvic_core_model.sv
// Processor core stand-in that accepts offered vectors
`timescale 1ns/100ps
`default_nettype none
module pvic_core_model (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_req,
  input wire logic i_enable,
  input wire logic [1:0] i_delay,
  output logic o_ack
);
  logic [1:0] wait_q;
  // Stall keeps a slow core in play; never two accepts in a row
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      wait_q <= 2'h0;
      o_ack <= 1'b0;
    end else begin
      o_ack <= i_req && i_enable && !o_ack && wait_q >= i_delay;
      wait_q <= (i_req && i_enable && !o_ack) ? wait_q + 2'h1 : 2'h0;
    end
  end
endmodule
`default_nettype wire

// ### tb/pvic_properties.sv
// Port checks for the vectored interrupt controller
`timescale 1ns/100ps
`default_nettype none
module pvic_properties
  import pvic_pkg::*;
(
  input wire logic I_CLOCK,
  input wire logic I_RST,
  input wire logic [NUM_VECTORS-1:0] I_LEVEL_SEL,
  input wire logic I_IRQ_ACK,
  input wire logic I_IRQ_RETURN,
  input wire logic O_IRQ_REQ,
  input wire logic [ADDR_W-1:0] O_IRQ_VECTOR,
  input wire logic [1:0] O_IRQ_LEVEL,
  input wire logic [2:0] O_IN_SERVICE,
  input wire logic [1:0] O_SERVICE_LEVEL
);
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (I_RST);
  logic [NUM_VECTORS-1:0] sel_q;
  logic [4:0] vi;
  logic [1:0] want;
  // No reset: must hold the choice seen at the edge before release
  always_ff @(posedge I_CLOCK) sel_q <= I_LEVEL_SEL;
  assign vi = O_IRQ_VECTOR[7:3];
  assign want = !sel_q[vi] ? 2'h1 : vi < 5'h02 ? 2'h3 : 2'h2;
  offer_above_bar_a: assert property (
    O_IRQ_REQ |-> O_IRQ_LEVEL > O_SERVICE_LEVEL) else $error("low offer");
  ack_drops_req_a: assert property (
    I_IRQ_ACK && O_IRQ_REQ |=> !O_IRQ_REQ) else $error("req after ack");
  ack_sets_level_a: assert property (
    I_IRQ_ACK && O_IRQ_REQ |=> O_SERVICE_LEVEL == $past(O_IRQ_LEVEL))
    else $error("bad service level");
  vector_grid_a: assert property (
    O_IRQ_REQ |-> O_IRQ_VECTOR[2:0] == 3'h3 && O_IRQ_VECTOR <= 20'h0004B)
    else $error("bad vector");
  top_pins_only_a: assert property (
    O_IRQ_REQ && O_IRQ_LEVEL == 2'h3 |-> O_IRQ_VECTOR <= 20'h0000B)
    else $error("top level off pins");
  level_from_sel_a: assert property (
    O_IRQ_REQ |-> O_IRQ_LEVEL == want) else $error("bad level");
  return_pops_a: assert property (
    I_IRQ_RETURN && !I_IRQ_ACK && O_IN_SERVICE != 3'h0
    |=> O_SERVICE_LEVEL < $past(O_SERVICE_LEVEL)) else $error("no pop");
  mask_holds_a: assert property (
    !I_IRQ_ACK && !I_IRQ_RETURN |=> $stable(O_IN_SERVICE))
    else $error("mask moved");
endmodule
bind priority_vector_interrupt_ctrl pvic_properties chk (
  .I_CLOCK(I_CLOCK),
  .I_RST(I_RST),
  .I_LEVEL_SEL(I_LEVEL_SEL),
  .I_IRQ_ACK(I_IRQ_ACK),
  .I_IRQ_RETURN(I_IRQ_RETURN),
  .O_IRQ_REQ(O_IRQ_REQ),
  .O_IRQ_VECTOR(O_IRQ_VECTOR),
  .O_IRQ_LEVEL(O_IRQ_LEVEL),
  .O_IN_SERVICE(O_IN_SERVICE),
  .O_SERVICE_LEVEL(O_SERVICE_LEVEL)
);
`default_nettype wire
